// [rdc_ctrl.sv]
// Direction and enable control for a differential line converter
`timescale 1ns/10ps
`default_nettype none
`include "rdc_cfg.svh"
module rdc_ctrl
  import rdc_pkg::*;
#(
  parameter int TURN_CYC = `RDC_TURN_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire rdc_sw_s switches,
  input wire rdc_chan_s term_in,
  output var rdc_chan_s term_out,
  input wire rdc_chan_s line_in,
  output var rdc_chan_s line_out,
  output var logic data_drv_oe_n,
  output var logic hs_drv_oe_n,
  output var logic data_rcv_en,
  output var logic hs_rcv_en,
  output var logic [2:0] mode,
  output var logic cfg_error
);
  typedef struct packed {
    rdc_chan_s term_out;
    rdc_chan_s line_out;
    logic data_drv_oe_n;
    logic hs_drv_oe_n;
    logic data_rcv_en;
    logic hs_rcv_en;
    rdc_mode_e mode;
    logic cfg_error;
    logic auto_tx;
    logic [`RDC_CNT_W-1:0] hold;
  } rdc_ctrl_s;
  rdc_ctrl_s st;
  rdc_ctrl_s next_st;
  rdc_sw_s sw_s;
  rdc_chan_s term_s;
  rdc_chan_s line_s;
  rdc_chan_s tx_word;
  logic tx_valid;
  logic tx_ready;
  rdc_mode_e dec_mode;
  logic drv_on;
  logic rcv_on;
  logic tx_active;
  logic [`RDC_CNT_W-1:0] turn_cnt;
  assign turn_cnt = `RDC_CNT_W'(TURN_CYC);
  // Reset to idle levels: marks high, terminal handshake negated, switches off
  rdc_sync #(.W(6)) u_sw_sync (
    .clk(clk),
    .srst(srst),
    .d(switches),
    .rst_val(6'h00),
    .q(sw_s)
  );
  rdc_sync #(.W(2)) u_term_sync (
    .clk(clk),
    .srst(srst),
    .d(term_in),
    .rst_val(2'h2),
    .q(term_s)
  );
  rdc_sync #(.W(2)) u_line_sync (
    .clk(clk),
    .srst(srst),
    .d(line_in),
    .rst_val(2'h3),
    .q(line_s)
  );
  // Outgoing path buffered so a stalled update loses no sample
  rdc_buf2 #(.W(2)) u_tx_buf (
    .clk(clk),
    .srst(srst),
    .in_data(term_s),
    .in_valid(1'b1),
    .in_ready(),
    .out_data(tx_word),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );
  assign tx_ready = 1'b1;
  always_comb begin
    dec_mode = RDC_INVALID;
    if (sw_s.fixed_on_switch && !sw_s.fixed_off_switch_a && !sw_s.fixed_off_switch_b) begin
      unique case ({sw_s.echo_suppress_switch, sw_s.auto_direction_switch,
                    sw_s.handshake_direction_switch})
        3'b000: dec_mode = RDC_MASTER;
        3'b001: dec_mode = RDC_HS_ECHO;
        3'b101: dec_mode = RDC_HS_QUIET;
        3'b010: dec_mode = RDC_AUTO_ECHO;
        3'b110: dec_mode = RDC_AUTO_QUIET;
        default: dec_mode = RDC_INVALID;
      endcase
    end
  end
  always_comb begin
    next_st = st;
    next_st.mode = dec_mode;
    next_st.cfg_error = (dec_mode == RDC_INVALID);
    tx_active = tx_valid && (tx_word.data != `RDC_MARK);
    // Hold timer restarts on every active bit
    if (tx_active) begin
      next_st.auto_tx = 1'b1;
      next_st.hold = turn_cnt;
    end else if (st.hold > 1) begin
      next_st.hold = st.hold - 1'b1;
    end else begin
      next_st.hold = '0;
      next_st.auto_tx = 1'b0;
    end
    drv_on = 1'b0;
    rcv_on = 1'b1;
    unique case (dec_mode)
      RDC_MASTER: drv_on = 1'b1;
      RDC_HS_ECHO, RDC_HS_QUIET: drv_on = term_s.handshake;
      RDC_AUTO_ECHO, RDC_AUTO_QUIET: drv_on = tx_active || next_st.auto_tx;
      default: drv_on = 1'b0;
    endcase
    if (dec_mode == RDC_HS_QUIET || dec_mode == RDC_AUTO_QUIET) begin
      rcv_on = !drv_on;
    end else begin
      rcv_on = (dec_mode != RDC_INVALID);
    end
    if (tx_valid) begin
      next_st.line_out = tx_word;
    end
    next_st.term_out = line_s;
    if (!rcv_on) begin
      next_st.term_out.data = `RDC_MARK;
    end
    next_st.data_drv_oe_n = !drv_on;
    next_st.hs_drv_oe_n = (dec_mode != RDC_MASTER);
    next_st.data_rcv_en = rcv_on;
    next_st.hs_rcv_en = (dec_mode == RDC_MASTER);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.term_out <= 2'h3;
      st.line_out <= 2'h3;
      st.data_drv_oe_n <= 1'b1;
      st.hs_drv_oe_n <= 1'b1;
      st.mode <= RDC_INVALID;
      st.cfg_error <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  assign term_out = st.term_out;
  assign line_out = st.line_out;
  assign data_drv_oe_n = st.data_drv_oe_n;
  assign hs_drv_oe_n = st.hs_drv_oe_n;
  assign data_rcv_en = st.data_rcv_en;
  assign hs_rcv_en = st.hs_rcv_en;
  assign mode = st.mode;
  assign cfg_error = st.cfg_error;
endmodule // rdc_ctrl
`default_nettype wire

// [rdc_cfg.svh]
// Constants for the line direction controller
// Notes on behaviour
// - One data and one handshake signal pass in each direction.
// - Bus master mode keeps all line drivers and receivers enabled continuously.
// - All selection switches off, fixed-on on, fixed-offs off selects bus master.
// - Handshake modes enable driver while handshake in is asserted, else high impedance.
// - Echo modes keep the line receiver enabled at all times.
// - Modes without echo disable the receiver while the driver is enabled.
// - Automatic modes enable the driver when outgoing data begins.
// - Automatic modes release the driver once transmission has finished.
// - Only handshake switch on selects handshake mode with echo.
// - Echo suppress and handshake switches on selects handshake mode without echo.
// - Only automatic switch on selects automatic mode with echo.
// - Echo suppress and automatic switches on selects automatic mode without echo.
// - Automatic control turns back to receive about ten microseconds after last data.
`ifndef RDC_CFG_SVH
`define RDC_CFG_SVH
`define RDC_CLK_MHZ 125
`define RDC_TURN_US 10
`define RDC_TURN_CYC (`RDC_TURN_US * `RDC_CLK_MHZ)
`define RDC_CNT_W 11
`define RDC_MARK 1'b1
`endif

// [rdc_pkg.sv]
// Types for the line direction controller
`default_nettype none
package rdc_pkg;
  typedef enum logic [2:0] {
    RDC_MASTER = 3'b000,
    RDC_HS_ECHO = 3'b001,
    RDC_HS_QUIET = 3'b010,
    RDC_AUTO_ECHO = 3'b011,
    RDC_AUTO_QUIET = 3'b100,
    RDC_INVALID = 3'b111
  } rdc_mode_e;
  typedef struct packed {
    logic echo_suppress_switch;
    logic auto_direction_switch;
    logic handshake_direction_switch;
    logic fixed_on_switch;
    logic fixed_off_switch_a;
    logic fixed_off_switch_b;
  } rdc_sw_s;
  typedef struct packed {
    logic data;
    logic handshake;
  } rdc_chan_s;
endpackage
`default_nettype wire

// [rdc_sync.sv]
// Two-flop synchroniser for a bus of pins
`timescale 1ns/10ps
`default_nettype none
module rdc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] rst_val,
  output var logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rdc_sync_s;
  rdc_sync_s st;
  rdc_sync_s next_st;
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      // Both stages rest at the pin's idle level, so no false edge follows reset
      st <= {rst_val, rst_val};
    end else begin
      st <= next_st;
    end
  end
  assign q = st.s2;
endmodule // rdc_sync
`default_nettype wire

// [rdc_buf2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module rdc_buf2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output var logic in_ready,
  output var logic [W-1:0] out_data,
  output var logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] cnt;
    logic rd;
    logic wr;
  } rdc_buf_s;
  rdc_buf_s st;
  rdc_buf_s next_st;
  logic push;
  logic pop;
  always_comb begin
    push = in_valid && (st.cnt != 2'h2);
    pop = (st.cnt != 2'h0) && out_ready;
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = ~st.wr;
    end
    if (pop) begin
      next_st.rd = ~st.rd;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign in_ready = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data = st.mem[st.rd];
endmodule // rdc_buf2
`default_nettype wire

// [rdc_ctrl_checker.sv]
// Assertion checker for the line direction controller
`timescale 1ns/10ps
`default_nettype none
module rdc_ctrl_checker
  import rdc_pkg::*;
#(
  parameter int TURN_CYC = 1250
) (
  input wire logic clk,
  input wire logic srst,
  input wire rdc_chan_s term_in,
  input wire logic data_drv_oe_n,
  input wire logic hs_drv_oe_n,
  input wire logic data_rcv_en,
  input wire logic hs_rcv_en,
  input wire logic [2:0] mode,
  input wire logic cfg_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [15:0] idle;
  logic auto;
  logic hs;
  assign auto = mode inside {3'h3, 3'h4};
  assign hs = mode inside {3'h1, 3'h2};
  // Cycles since the outgoing data was last at space
  always_ff @(posedge clk) begin
    if (srst) begin
      idle <= 16'hffff;
    end else if (!term_in.data) begin
      idle <= 16'h0000;
    end else if (idle != 16'hffff) begin
      idle <= idle + 16'h0001;
    end
  end
  a_master_all_on: assert property ((mode == 3'h0)[*2] |-> !data_drv_oe_n && !hs_drv_oe_n && data_rcv_en && hs_rcv_en)
    else $error("master enables wrong");
  a_echo_rcv_on: assert property ((mode inside {3'h1, 3'h3})[*2] |-> data_rcv_en)
    else $error("echo receiver off");
  a_quiet_rcv_swap: assert property ((mode inside {3'h2, 3'h4})[*2] |-> data_rcv_en == data_drv_oe_n)
    else $error("quiet receiver wrong");
  a_hs_drive_on: assert property (term_in.handshake[*8] ##0 hs |-> !data_drv_oe_n)
    else $error("handshake driver off");
  a_hs_drive_off: assert property ((!term_in.handshake)[*8] ##0 hs |-> data_drv_oe_n)
    else $error("handshake driver on");
  a_auto_hold: assert property (auto && idle inside {[6:TURN_CYC]} |-> !data_drv_oe_n)
    else $error("auto driver dropped early");
  a_auto_release: assert property (auto && idle > 16'(TURN_CYC + 8) |-> data_drv_oe_n)
    else $error("auto driver held late");
  a_cfg_all_off: assert property (cfg_error |-> data_drv_oe_n && hs_drv_oe_n && !data_rcv_en && !hs_rcv_en)
    else $error("bad setting left enables");
  c_hs_drive: cover property (hs && !data_drv_oe_n);
  c_auto_quiet: cover property (mode == 3'h4 && !data_drv_oe_n);
  c_refused: cover property (cfg_error);
endmodule // rdc_ctrl_checker
bind rdc_ctrl rdc_ctrl_checker #(.TURN_CYC(TURN_CYC)) u_chk (.clk(clk), .srst(srst), .term_in(term_in),
  .data_drv_oe_n(data_drv_oe_n), .hs_drv_oe_n(hs_drv_oe_n), .data_rcv_en(data_rcv_en),
  .hs_rcv_en(hs_rcv_en), .mode(mode), .cfg_error(cfg_error));
`default_nettype wire

// [rdc_bus_station.sv]
// Bus station model on the far side of the line
`timescale 1ns/10ps
`default_nettype none
module rdc_bus_station
  import rdc_pkg::*;
(
  input wire logic data_drv_oe_n,
  input wire rdc_chan_s line_out,
  input wire logic tx_en,
  input wire rdc_chan_s tx,
  output var rdc_chan_s line_in
);
  // Released bus rests at mark through termination
  always_comb begin
    line_in.data = tx_en ? tx.data : (!data_drv_oe_n ? line_out.data : 1'b1);
    line_in.handshake = tx_en ? tx.handshake : 1'b1;
  end
endmodule // rdc_bus_station
`default_nettype wire

// [rdc_ctrl_tb_top.sv]
// Testbench for the line direction controller
`timescale 1ns/10ps
`default_nettype none
module rdc_ctrl_tb_top;
  import rdc_pkg::*;
  localparam int TC = 16;
  logic clk, srst, tx_en, data_drv_oe_n, hs_drv_oe_n, data_rcv_en, hs_rcv_en, cfg_error;
  logic [2:0] mode;
  rdc_sw_s switches;
  rdc_chan_s term_in, term_out, line_in, line_out, tx;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [5:0] sw_tab [6] = '{6'h04, 6'h0c, 6'h2c, 6'h14, 6'h34, 6'h30};
  rdc_ctrl #(.TURN_CYC(TC)) dut (.clk(clk), .srst(srst), .switches(switches), .term_in(term_in),
    .term_out(term_out), .line_in(line_in), .line_out(line_out), .data_drv_oe_n(data_drv_oe_n),
    .hs_drv_oe_n(hs_drv_oe_n), .data_rcv_en(data_rcv_en), .hs_rcv_en(hs_rcv_en), .mode(mode), .cfg_error(cfg_error));
  rdc_bus_station stn (.data_drv_oe_n(data_drv_oe_n), .line_out(line_out), .tx_en(tx_en), .tx(tx), .line_in(line_in));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    srst = 1'b1;
    tx_en = 1'b0;
    tx = 2'b11;
    term_in = 2'b10;
    switches = 6'h04;
    cyc(6);
    srst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      switches = sw_tab[i];
      cyc(8);
      chk("mode", {cfg_error, mode}, (i < 5) ? 4'(i) : 4'hf);
      chk("enables", {hs_drv_oe_n, data_drv_oe_n, hs_rcv_en, data_rcv_en}, i == 0 ? 4'h3 : i < 5 ? 4'hd : 4'hc);
    end
    $display("modes done");
    for (int i = 1; i < 3; i++) begin
      switches = sw_tab[i];
      term_in.handshake = 1'b1;
      cyc(8);
      chk("hs on", {2'b00, data_drv_oe_n, data_rcv_en}, {3'b000, 1'(i == 1)});
      term_in.handshake = 1'b0;
      cyc(8);
      chk("hs off", {2'b00, data_drv_oe_n, data_rcv_en}, 4'h3);
    end
    $display("handshake done");
    for (int i = 3; i < 5; i++) begin
      switches = sw_tab[i];
      cyc(8);
      term_in.data = 1'b0;
      cyc(8);
      chk("auto on", {line_out.data, data_drv_oe_n, data_rcv_en, term_out.data}, {2'b00, 1'(i == 3), 1'(i == 4)});
      term_in.data = 1'b1;
      cyc(TC - 2);
      chk("auto hold", {3'b000, data_drv_oe_n}, 4'h0);
      cyc(8);
      chk("auto off", {2'b00, data_drv_oe_n, data_rcv_en}, 4'h3);
    end
    $display("auto done");
    switches = sw_tab[0];
    tx_en = 1'b1;
    tx = 2'b01;
    term_in = 2'b10;
    cyc(8);
    chk("relay", {term_out, line_out}, 4'h6);
    tx = 2'b10;
    term_in = 2'b01;
    cyc(8);
    chk("relay", {term_out, line_out}, 4'h9);
    $display("relay done");
    finish_test();
  end
endmodule // rdc_ctrl_tb_top
`default_nettype wire
